// *** inc/pcp_params.svh ***
// Purpose: Offsets, field positions, reset values and fixed figures of the pixel correction pipeline
// Assumes: Included by bare name; definitions only
// Notes: Byte addresses on the AXI4-Lite register port
`ifndef PCP_PARAMS_SVH
`define PCP_PARAMS_SVH

// Register byte offsets
`define PCP_REG_CTRL 8'h00
`define PCP_REG_STATUS 8'h04
`define PCP_REG_WIN_X 8'h08
`define PCP_REG_WIN_Y 8'h0C
`define PCP_REG_TILES_X 8'h10
`define PCP_REG_SHADE_ADDR 8'h14
`define PCP_REG_SHADE_DATA 8'h18
`define PCP_REG_DEFECT_ADDR 8'h1C
`define PCP_REG_DEFECT_DATA 8'h20
`define PCP_REG_DEFECT_CNT 8'h24
`define PCP_REG_MAP_ADDR 8'h28
`define PCP_REG_MAP_DATA 8'h2C

// Control fields and the list select bit of the defect address register
`define PCP_CTRL_SHADE_EN 0
`define PCP_CTRL_DEFECT_EN 1
`define PCP_CTRL_MAP_EN 2
`define PCP_CTRL_CUSTOM_SEL 3
`define PCP_CTRL_WIN_EN 4
`define PCP_DEFECT_ADDR_SEL 15

// Reset values
`define PCP_CTRL_RESET 32'h0000_0000
`define PCP_WIN_RESET 32'h0000_0000
`define PCP_TILES_X_RESET 16'h0000

// Fixed figures
`define PCP_TILE_SHIFT 4
`define PCP_GAIN_FRAC 12
`define PCP_PIX_MAX 12'hFFF
`define PCP_RESP_OKAY 2'h0
`define PCP_RESP_SLVERR 2'h2

`endif

// *** inc/pcp_pkg.sv ***
// Purpose: Shared types of the pixel correction pipeline
// Assumes: Used by scoped names only
// Notes: Numbers live in pcp_params.svh
`default_nettype none
package pcp_pkg;
  typedef logic [11:0] pcp_pix_type;
  typedef logic [7:0] pcp_narrow_type;
  typedef logic [15:0] pcp_coord_type;
  typedef logic [1:0] pcp_resp_type;
endpackage
`default_nettype wire

// *** hdl/pcp_fifo.sv ***
// Purpose: Output buffer with valid/ready on both sides
// Assumes: DEPTH a power of two, at least 2
// Notes: Read data come straight from the storage flops
`default_nettype none
module pcp_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // Refuse shapes the pointers cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
    $error("pcp_fifo: DEPTH must be a power of two and at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;

  // Full and empty from the extra pointer bit
  assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];

  // Storage
  always_ff @(posedge aclk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** hdl/pcp_top.sv ***
// Purpose: Streaming shading, defect and value-map correction with a readout window
// Assumes: Pixels arrive in raster order, one beat per accepted cycle
// Notes: Maps and lists are loaded over AXI4-Lite before their stage is enabled
// Function
// R01: Frame is cut into 16x16 tiles, each tile addressing one shading map entry.
// R02: Each pixel gets its tile's gain and offset applied for flat field.
// R03: Shading map is loaded from outside and used for every later frame.
// R04: Single bad pixels and runs of up to five adjacent ones are repaired.
// R05: A flagged pixel takes its left or right neighbour instead of its own value.
// R06: A factory defect list and a custom coordinate list are both held on chip.
// R07: Defect repair can be switched off and on again while running.
// R08: Value map holds one programmable output per possible 12-bit input code.
// R09: With the value map in use, 12-bit samples leave as 8-bit samples.
// R10: Gamma curves are computed outside and loaded as plain map contents.
// R11: With a window set, only pixels inside it are forwarded.
// R12: Lines outside a reduced window height are dropped, cutting data per frame.
// R13: Output beats carry line valid and frame valid qualifiers.
// R14: Order is shading, defect repair, value map; each stage has its own enable.
// R15: Qualifiers travel through the same stages as the data, so stay aligned.
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`include "pcp_params.svh"
`default_nettype none
module pcp_top #(
  parameter int TILE_DEPTH = 4096,
  parameter int DEFECT_DEPTH = 64,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pix_in_valid,
  output logic pix_in_ready,
  input wire logic [11:0] pix_in_data,
  input wire logic pix_in_line_valid,
  input wire logic pix_in_frame_valid,
  output logic pix_out_valid,
  input wire logic pix_out_ready,
  output logic [11:0] pix_out_data,
  output logic line_valid,
  output logic frame_valid
);
  localparam int TW = $clog2(TILE_DEPTH);
  localparam int DW = $clog2(DEFECT_DEPTH);
  localparam int STAGES = 6;

  // Refuse depths the address logic cannot serve
  if ((1 << TW) != TILE_DEPTH || (1 << DW) != DEFECT_DEPTH || DW > 15 || TW > 24) begin : g_bad
    $error("pcp_top: map depths must be powers of two within the address fields");
  end

  // Byte-lane merge for plain registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ---------------- Register port ----------------
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] rd_mux;
  logic [31:0] ctrl;
  logic [31:0] win_x;
  logic [31:0] win_y;
  logic [15:0] tiles_x;
  logic [TW-1:0] shade_addr;
  logic [DW:0] defect_addr;
  logic [31:0] defect_cnt;
  logic [11:0] map_addr;
  logic frame_active;
  logic [15:0] frame_count;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  // Address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (wr_go) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // Decode of mapped words
  always_comb begin
    wr_ok = 1'b1;
    unique case (aw_addr)
      `PCP_REG_CTRL, `PCP_REG_STATUS, `PCP_REG_WIN_X, `PCP_REG_WIN_Y, `PCP_REG_TILES_X,
      `PCP_REG_SHADE_ADDR, `PCP_REG_SHADE_DATA, `PCP_REG_DEFECT_ADDR, `PCP_REG_DEFECT_DATA,
      `PCP_REG_DEFECT_CNT, `PCP_REG_MAP_ADDR, `PCP_REG_MAP_DATA: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PCP_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? `PCP_RESP_OKAY : `PCP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Plain settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `PCP_CTRL_RESET;
      win_x <= `PCP_WIN_RESET;
      win_y <= `PCP_WIN_RESET;
      tiles_x <= `PCP_TILES_X_RESET;
      defect_cnt <= 32'h0000_0000;
    end else if (wr_go) begin
      unique case (aw_addr)
        `PCP_REG_CTRL: ctrl <= merge(ctrl, w_data, w_strb) & 32'h0000_001F; // [R07] [R14]
        `PCP_REG_WIN_X: win_x <= merge(win_x, w_data, w_strb);
        `PCP_REG_WIN_Y: win_y <= merge(win_y, w_data, w_strb);
        `PCP_REG_TILES_X: tiles_x <= 16'(merge({16'h0000, tiles_x}, w_data, w_strb));
        `PCP_REG_DEFECT_CNT: defect_cnt <= merge(defect_cnt, w_data, w_strb);
        default: ;
      endcase
    end
  end

  // Auto-incrementing map address pointers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shade_addr <= '0;
      defect_addr <= '0;
      map_addr <= 12'h000;
    end else if (wr_go) begin
      unique case (aw_addr)
        `PCP_REG_SHADE_ADDR: shade_addr <= w_data[TW-1:0];
        `PCP_REG_SHADE_DATA: shade_addr <= shade_addr + 1'b1;
        `PCP_REG_DEFECT_ADDR: defect_addr <= {w_data[`PCP_DEFECT_ADDR_SEL], w_data[DW-1:0]};
        `PCP_REG_DEFECT_DATA: defect_addr <= {defect_addr[DW], defect_addr[DW-1:0] + 1'b1};
        `PCP_REG_MAP_ADDR: map_addr <= w_data[11:0];
        `PCP_REG_MAP_DATA: map_addr <= map_addr + 1'b1;
        default: ;
      endcase
    end
  end

  // Read data mux
  always_comb begin
    rd_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (s_axi_araddr)
      `PCP_REG_CTRL: rd_mux = ctrl;
      `PCP_REG_STATUS: rd_mux = {frame_count, 15'h0000, frame_active};
      `PCP_REG_WIN_X: rd_mux = win_x;
      `PCP_REG_WIN_Y: rd_mux = win_y;
      `PCP_REG_TILES_X: rd_mux = {16'h0000, tiles_x};
      `PCP_REG_SHADE_ADDR: rd_mux = 32'(shade_addr);
      `PCP_REG_DEFECT_ADDR: rd_mux = 32'(defect_addr[DW-1:0]) | (32'(defect_addr[DW]) << `PCP_DEFECT_ADDR_SEL);
      `PCP_REG_DEFECT_CNT: rd_mux = defect_cnt;
      `PCP_REG_MAP_ADDR: rd_mux = {20'h0_0000, map_addr};
      `PCP_REG_SHADE_DATA, `PCP_REG_DEFECT_DATA, `PCP_REG_MAP_DATA: rd_mux = 32'h0000_0000;
      default: rd_ok = 1'b0;
    endcase
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PCP_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? `PCP_RESP_OKAY : `PCP_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- Maps ----------------
  logic [27:0] shade_mem [TILE_DEPTH];
  logic [31:0] defect_mem [2*DEFECT_DEPTH];
  pcp_pkg::pcp_narrow_type map_mem [4096];
  logic [27:0] shade_q;
  logic [31:0] defect_q;
  pcp_pkg::pcp_narrow_type map_q;

  // Map loads from the register port
  always_ff @(posedge aclk) begin
    if (wr_go && aw_addr == `PCP_REG_SHADE_DATA) begin
      shade_mem[shade_addr] <= w_data[27:0]; // [R03]
    end
    if (wr_go && aw_addr == `PCP_REG_DEFECT_DATA) begin
      defect_mem[defect_addr] <= w_data; // [R06]
    end
    if (wr_go && aw_addr == `PCP_REG_MAP_DATA) begin
      map_mem[map_addr] <= w_data[7:0]; // [R08] [R10]
    end
  end

  // ---------------- Input side and window ----------------
  logic adv;
  logic beat;
  logic in_pix;
  logic keep;
  logic first;
  logic lv_prev;
  logic fv_prev;
  pcp_pkg::pcp_coord_type col;
  pcp_pkg::pcp_coord_type row;
  logic [TW-1:0] tile_idx;
  logic sel;
  logic [DW:0] dptr;
  logic [DW:0] next_dptr;
  logic match;
  logic [15:0] dcount;
  logic fifo_ready;

  assign adv = fifo_ready;
  assign pix_in_ready = fifo_ready;
  assign beat = pix_in_valid && adv;
  assign in_pix = pix_in_line_valid && pix_in_frame_valid;
  assign keep = !in_pix || !ctrl[`PCP_CTRL_WIN_EN] || (
    {1'b0, col} >= {1'b0, win_x[15:0]} && {1'b0, col} < {1'b0, win_x[15:0]} + {1'b0, win_x[31:16]} &&
    {1'b0, row} >= {1'b0, win_y[15:0]} && {1'b0, row} < {1'b0, win_y[15:0]} + {1'b0, win_y[31:16]}); // [R11] [R12]
  assign first = col == (ctrl[`PCP_CTRL_WIN_EN] ? win_x[15:0] : 16'h0000);
  assign tile_idx = TW'((row >> `PCP_TILE_SHIFT) * tiles_x + (col >> `PCP_TILE_SHIFT)); // [R01]

  // Raster position and frame status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      col <= 16'h0000;
      row <= 16'h0000;
      lv_prev <= 1'b0;
      fv_prev <= 1'b0;
      frame_count <= 16'h0000;
    end else if (beat) begin
      col <= in_pix ? col + 1'b1 : 16'h0000;
      row <= !pix_in_frame_valid ? 16'h0000 : row + 16'(lv_prev && !pix_in_line_valid);
      lv_prev <= pix_in_line_valid;
      fv_prev <= pix_in_frame_valid;
      frame_count <= frame_count + 16'(fv_prev && !pix_in_frame_valid);
    end
  end
  assign frame_active = fv_prev;

  // Sorted defect list walked alongside the raster
  assign dcount = sel ? defect_cnt[31:16] : defect_cnt[15:0];
  assign match = beat && in_pix && 16'(dptr[DW-1:0]) < dcount && !dptr[DW] && defect_q == {row, col}; // [R04]
  assign next_dptr = !pix_in_frame_valid ? '0 : dptr + (DW+1)'(match);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dptr <= '0;
      sel <= 1'b0;
    end else begin
      dptr <= next_dptr;
      if (!pix_in_frame_valid) begin
        sel <= ctrl[`PCP_CTRL_CUSTOM_SEL]; // [R06]
      end
    end
  end
  always_ff @(posedge aclk) begin
    defect_q <= defect_mem[{sel, next_dptr[DW-1:0]}];
  end

  // ---------------- Stages ----------------
  logic [STAGES-1:0] sv;
  logic [STAGES-1:0] slv;
  logic [STAGES-1:0] sfv;
  logic [STAGES-1:0] spx;
  logic [STAGES-1:0] sfirst;
  logic [STAGES-1:0] sdf;
  pcp_pkg::pcp_pix_type d0;
  pcp_pkg::pcp_pix_type d1;
  pcp_pkg::pcp_pix_type d2;
  pcp_pkg::pcp_pix_type d3;
  pcp_pkg::pcp_pix_type d4;
  pcp_pkg::pcp_pix_type d5;
  pcp_pkg::pcp_pix_type shaded;
  pcp_pkg::pcp_pix_type fixed;
  pcp_pkg::pcp_pix_type last_good;
  logic [27:0] prod;
  logic signed [17:0] sum;

  // Qualifiers shifted with the data, one place per stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sv <= '0;
      slv <= '0;
      sfv <= '0;
      spx <= '0;
      sfirst <= '0;
      sdf <= '0;
    end else if (adv) begin
      sv <= {sv[STAGES-2:0], beat && keep}; // [R15]
      slv <= {slv[STAGES-2:0], pix_in_line_valid}; // [R15]
      sfv <= {sfv[STAGES-2:0], pix_in_frame_valid}; // [R15]
      spx <= {spx[STAGES-2:0], in_pix};
      sfirst <= {sfirst[STAGES-2:0], first};
      sdf <= {sdf[STAGES-2:0], match};
    end
  end

  // Tile gain and offset
  always_comb begin
    prod = 28'(d0) * 28'(shade_q[15:0]);
    sum = $signed({2'b00, prod[27:`PCP_GAIN_FRAC]}) + $signed({{6{shade_q[27]}}, shade_q[27:16]});
    if (sum < 0) begin
      shaded = 12'h000;
    end else if (sum > $signed({6'h00, `PCP_PIX_MAX})) begin
      shaded = `PCP_PIX_MAX;
    end else begin
      shaded = sum[11:0];
    end
  end

  // Neighbour replacement: left if the line has one, else right
  always_comb begin
    fixed = d3;
    if (ctrl[`PCP_CTRL_DEFECT_EN] && sv[3] && spx[3] && sdf[3]) begin // [R07]
      if (!sfirst[3]) begin
        fixed = last_good; // [R05] [R04]
      end else if (sv[2] && spx[2] && !sfirst[2]) begin
        fixed = d2; // [R05]
      end
    end
  end

  // Data path: shading, defect repair, value map
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      d0 <= 12'h000;
      d1 <= 12'h000;
      d2 <= 12'h000;
      d3 <= 12'h000;
      d4 <= 12'h000;
      d5 <= 12'h000;
      last_good <= 12'h000;
    end else if (adv) begin
      d0 <= pix_in_data;
      d1 <= ctrl[`PCP_CTRL_SHADE_EN] ? shaded : d0; // [R02] [R14]
      d2 <= d1;
      d3 <= d2;
      d4 <= fixed; // [R14]
      d5 <= ctrl[`PCP_CTRL_MAP_EN] ? {4'h0, map_q} : d4; // [R09] [R14]
      if (sv[3] && spx[3]) begin
        last_good <= fixed; // [R04]
      end
    end
  end

  // Registered map reads
  always_ff @(posedge aclk) begin
    if (adv) begin
      shade_q <= shade_mem[tile_idx]; // [R01] [R03]
      map_q <= map_mem[fixed]; // [R08]
    end
  end

  // ---------------- Output buffer ----------------
  logic [13:0] fifo_out;

  pcp_fifo #(
    .WIDTH(14),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(sv[STAGES-1] && adv),
    .in_ready(fifo_ready),
    .in_data({sfv[STAGES-1], slv[STAGES-1], d5}),
    .out_valid(pix_out_valid),
    .out_ready(pix_out_ready),
    .out_data(fifo_out)
  );

  // Qualified output beat
  assign frame_valid = fifo_out[13]; // [R13]
  assign line_valid = fifo_out[12]; // [R13]
  assign pix_out_data = fifo_out[11:0];
endmodule
`default_nettype wire

// *** tb/pcp_assertions.sv ***
// Purpose: Concurrent checks on the ports of the correction pipeline
// Assumes: Bound to every instance of the top module
// Notes: One clock domain, synchronous active-low reset
`default_nettype none
module pcp_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic pix_in_valid,
  input wire logic pix_in_ready,
  input wire logic pix_in_frame_valid,
  input wire logic pix_out_valid,
  input wire logic pix_out_ready,
  input wire logic [11:0] pix_out_data,
  input wire logic line_valid,
  input wire logic frame_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Address and data taken together
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Blanking beat accepted at the input
  sequence blank_in;
    pix_in_valid && pix_in_ready && !pix_in_frame_valid;
  endsequence
  chk_write_answer: assert property (wr_taken |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after request");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after request");
  chk_resp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response stays after handshake");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  chk_out_hold: assert property (pix_out_valid && !pix_out_ready |=> pix_out_valid
    && $stable(pix_out_data) && $stable(line_valid) && $stable(frame_valid))
    else $error("output beat changed while stalled");
  chk_beat_pass: assert property (blank_in |-> ##[1:40] pix_out_valid)
    else $error("blanking beat never reached output");
  chk_reset_idle: assert property ($rose(aresetn) |-> !pix_out_valid && pix_in_ready
    && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not idle after reset");
  chk_full_ready: assert property (!pix_in_ready |-> pix_out_valid)
    else $error("input refused with empty buffer");
  chk_line_frame: assert property (pix_out_valid && line_valid |-> frame_valid)
    else $error("line valid outside frame");
endmodule
bind pcp_top pcp_assertions chk_u (.*);
`default_nettype wire

// *** tb/pcp_sink.sv ***
// Purpose: Image transport model at the output of the pipeline
// Assumes: Mode 0 always ready, 1 stalled, 2 every other cycle
// Notes: Ready changes only at rising edges
`default_nettype none
module pcp_sink (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] mode,
  output logic pix_out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ready pattern per mode
  always_ff @(posedge aclk) begin
    if (!aresetn) pix_out_ready <= 1'b0;
    else if (mode == 2'h0) pix_out_ready <= 1'b1;
    else if (mode == 2'h1) pix_out_ready <= 1'b0;
    else pix_out_ready <= !pix_out_ready;
  end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: Self-checking bench of the pixel correction pipeline
// Assumes: Inputs change by non-blocking assignment at rising edges
// Notes: Register rows first, streams and reset by hand after
`include "pcp_params.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic [1:0] resp;} pcp_tb_row_type;
  logic aclk = '0;
  logic aresetn = '0;
  logic [1:0] mode = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic pix_in_valid = '0, pix_in_line_valid = '0, pix_in_frame_valid = '0;
  logic [11:0] pix_in_data = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic [31:0] s_axi_rdata, rv;
  logic pix_in_ready, pix_out_valid, pix_out_ready, line_valid, frame_valid;
  logic [11:0] pix_out_data, v;
  logic [11:0] pin[$], got[$], exp_q[$];
  int failures = 0, n_tests = 0, cyc = 0, k;
  pcp_tb_row_type rows[6] = '{
    '{`PCP_REG_CTRL, 32'h0000_0015, 32'h0000_0015, `PCP_RESP_OKAY},
    '{`PCP_REG_WIN_X, 32'h0004_0002, 32'h0004_0002, `PCP_RESP_OKAY},
    '{`PCP_REG_WIN_Y, 32'h0001_0001, 32'h0001_0001, `PCP_RESP_OKAY},
    '{`PCP_REG_TILES_X, 32'h0000_0002, 32'h0000_0002, `PCP_RESP_OKAY},
    '{`PCP_REG_STATUS, 32'hffff_ffff, 32'h0000_0000, `PCP_RESP_OKAY},
    '{8'h30, 32'h0000_0001, 32'h0000_0000, `PCP_RESP_SLVERR}};

  pcp_top #(.FIFO_DEPTH(8)) dut_u (.*);
  pcp_sink sink_u (.*);

  // Clock and hang guard
  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end
  // Collect line-valid output beats
  always @(posedge aclk) if (pix_out_valid && pix_out_ready && line_valid) got.push_back(pix_out_data);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // One beat, held until taken
  task automatic beat(input logic [11:0] d, input logic lv, input logic fv);
    pix_in_valid <= 1'b1;
    pix_in_data <= d;
    pix_in_line_valid <= lv;
    pix_in_frame_valid <= fv;
    do @(posedge aclk); while (!pix_in_ready);
  endtask

  // Frame from the pin queue, blanking between lines
  task automatic frame(input int nl, input int w);
    @(posedge aclk);
    beat(12'h000, 1'b0, 1'b0);
    for (int r = 0; r < nl; r++) begin
      for (int c = 0; c < w; c++) beat(pin.pop_front(), 1'b1, 1'b1);
      beat(12'h000, 1'b0, 1'b1);
    end
    beat(12'h000, 1'b0, 1'b0);
    pix_in_valid <= 1'b0;
  endtask

  task automatic drain();
    int t;
    t = 0;
    while (got.size() < exp_q.size() && t < 500) begin
      @(posedge aclk);
      t++;
    end
    repeat (20) @(posedge aclk);
    check(got.size(), exp_q.size(), "beat count");
    foreach (exp_q[i]) if (i < got.size()) check(got[i], exp_q[i], "pixel");
    got.delete();
    exp_q.delete();
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w, br);
      check(br, rows[i].resp, "write response");
      rd(rows[i].a, rv, rr);
      check(rv, rows[i].r, "read data");
      check(rr, rows[i].resp, "read response");
    end
    // Latency and qualifiers of one bypassed beat
    wr(`PCP_REG_CTRL, 32'h0000_0000, br);
    @(posedge aclk);
    beat(12'habc, 1'b0, 1'b1);
    pix_in_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (!pix_out_valid && k < 50);
    check(k, 7, "latency");
    check({line_valid, frame_valid, pix_out_data}, {2'b01, 12'habc}, "qualified beat");
    // Buffer fills with the sink stalled, then drains
    mode <= 2'h1;
    for (int c = 0; c < 20; c++) pin.push_back(12'h100 + 12'(c));
    exp_q = pin;
    fork
      frame(1, 20);
    join_none
    repeat (60) @(posedge aclk);
    check(pix_in_ready, 0, "ready when full");
    mode <= 2'h2;
    wait fork;
    drain();
    check(pix_out_valid, 0, "drained");
    // Shading over two tiles, two frames
    mode <= 2'h0;
    wr(`PCP_REG_SHADE_ADDR, 32'h0000_0000, br);
    wr(`PCP_REG_SHADE_DATA, 32'h0005_1000, br);
    wr(`PCP_REG_SHADE_DATA, 32'h0000_2000, br);
    wr(`PCP_REG_CTRL, 32'h0000_0001, br);
    repeat (2) begin
      for (int c = 0; c < 32; c++) begin
        v = c < 16 ? 12'h100 + 12'(c) : c == 31 ? 12'h900 : 12'h200 + 12'(c);
        pin.push_back(v);
        exp_q.push_back(c < 16 ? v + 12'h005 : c == 31 ? 12'hfff : {v[10:0], 1'b0});
      end
      frame(1, 32);
    end
    drain();
    // Defect lists: factory on, off, custom
    wr(`PCP_REG_DEFECT_ADDR, 32'h0000_0000, br);
    for (int c = 3; c < 10; c++) if (c != 8) wr(`PCP_REG_DEFECT_DATA, c, br);
    wr(`PCP_REG_DEFECT_ADDR, 32'h0000_8000, br);
    wr(`PCP_REG_DEFECT_DATA, 32'h0000_0000, br);
    wr(`PCP_REG_DEFECT_CNT, 32'h0001_0006, br);
    for (int m = 0; m < 3; m++) begin
      wr(`PCP_REG_CTRL, m == 0 ? 32'h0000_0002 : m == 1 ? 32'h0000_0000 : 32'h0000_000a, br);
      for (int c = 0; c < 10; c++) begin
        v = 12'h300 + 12'(c * 7);
        pin.push_back(v);
        exp_q.push_back((m == 0 && c > 2 && c != 8) ? exp_q[$] : (m == 2 && c == 0) ? 12'h307 : v);
      end
      frame(1, 10);
    end
    drain();
    // Curve computed here, shading then value map
    wr(`PCP_REG_MAP_ADDR, 32'h0000_0000, br);
    for (int c = 0; c < 21; c++) wr(`PCP_REG_MAP_DATA, c * 9 + 1, br);
    wr(`PCP_REG_MAP_ADDR, 32'h0000_0fff, br);
    wr(`PCP_REG_MAP_DATA, 32'h0000_005a, br);
    wr(`PCP_REG_CTRL, 32'h0000_0005, br);
    for (int c = 0; c < 17; c++) begin
      pin.push_back(c < 16 ? 12'(c) : 12'h900);
      exp_q.push_back(c < 16 ? 12'(c * 9 + 46) : 12'h05a);
    end
    frame(1, 17);
    drain();
    // Readout window of one line, four columns
    wr(`PCP_REG_CTRL, 32'h0000_0010, br);
    for (int r = 0; r < 3; r++) for (int c = 0; c < 8; c++) begin
      pin.push_back(12'(r * 16 + c));
      if (r == 1 && c > 1 && c < 6) exp_q.push_back(12'(r * 16 + c));
    end
    frame(3, 8);
    drain();
    // Second reset clears settings and output
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PCP_REG_CTRL, rv, rr);
    check(rv, 32'h0000_0000, "control after reset");
    check(pix_out_valid, 0, "output after reset");
    end_of_test();
  end
endmodule
`default_nettype wire
